// *** pci_bridge_params.svh ***
`ifndef PCI_BRIDGE_PARAMS_SVH
`define PCI_BRIDGE_PARAMS_SVH

// Buffer geometry: each buffer holds 128 bytes of 32-bit words.
`define BUF_BYTES 128
`define WORD_BYTES 4
`define BUF_WORDS (`BUF_BYTES / `WORD_BYTES)
`define NUM_WR_BUFS 2
`define NUM_RD_BUFS 4
`define NUM_BUFS (`NUM_WR_BUFS + `NUM_RD_BUFS)

// Buffer entry layout: marker, command, byte enables, address or data.
`define ENT_W 41
`define ENT_ADDR_BIT 40
`define ENT_CMD_LSB 36
`define ENT_BE_LSB 32
`define ENT_DATA_MSB 31

// Write buffer indices for downstream and upstream traffic.
`define WR_DOWN_IDX 0
`define WR_UP_IDX 1
`define RD_BASE_IDX 2

// Medium decode: device select on the second edge after the address.
`define DEVSEL_EDGES 2
`define BURST_WORDS_DEF 8

// Address low bits for linear order and configuration types.
`define LINEAR_ORDER 2'h0
`define CFG_TYPE0 2'h0
`define CFG_TYPE1 2'h1

// Reset values of the driven pin signals.
`define PIN_IDLE 1'b1
`define AD_RST 32'h0000_0000

`endif

// *** pci_bridge_pkg.sv ***
package pci_bridge_pkg;

  typedef enum logic [3:0] {
    CMD_INT_ACK = 4'h0,
    CMD_SPECIAL = 4'h1,
    CMD_IO_RD = 4'h2,
    CMD_IO_WR = 4'h3,
    CMD_RSV4 = 4'h4,
    CMD_RSV5 = 4'h5,
    CMD_MEM_RD = 4'h6,
    CMD_MEM_WR = 4'h7,
    CMD_RSV8 = 4'h8,
    CMD_RSV9 = 4'h9,
    CMD_CFG_RD = 4'hA,
    CMD_CFG_WR = 4'hB,
    CMD_MEM_RD_MULT = 4'hC,
    CMD_DUAL_ADDR = 4'hD,
    CMD_MEM_RD_LINE = 4'hE,
    CMD_MEM_WR_INV = 4'hF
  } bus_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC1 = 3'b001,
    ST_DEC2 = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100,
    ST_WAIT = 3'b101
  } tgt_state_t;

endpackage

// *** txn_buffer.sv ***
`timescale 1ns/1ps
`include "pci_bridge_params.svh"

module txn_buffer #(
  parameter int W = `ENT_W,
  parameter int DEPTH = `BUF_WORDS
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  input wire logic [W-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [W-1:0] o_data,
  input wire logic i_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  // The output stage reloads whenever the memory holds an entry and the stage is empty or being taken.
  assign push = i_valid && o_ready;
  assign pop = (count_q != '0) && (!o_valid || i_ready);

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wptr_q] <= i_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
      o_ready <= 1'b1;
    end else begin
      if (push) begin
        wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
      end
      if (pop) begin
        rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push) - CW'(pop);
      o_ready <= (count_q + CW'(push) - CW'(pop)) < CW'(DEPTH);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_data <= '0;
    end else if (pop) begin
      o_valid <= 1'b1;
      o_data <= mem_q[rptr_q];
    end else if (i_ready) begin
      o_valid <= 1'b0;
    end
  end

endmodule

// *** pci_bridge_command_decode.sv ***
`timescale 1ns/1ps
`include "pci_bridge_params.svh"

module pci_bridge_command_decode #(
  parameter bit IS_PRIMARY = 1'b1,
  parameter int BURST_WORDS = `BURST_WORDS_DEF,
  parameter int DEPTH = `BUF_WORDS
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Bus pins seen as target
  input wire logic i_frame_n,
  input wire logic i_irdy_n,
  input wire logic i_idsel,
  input wire logic [31:0] i_ad,
  input wire logic [3:0] i_primary_cmd_byte_enable_n,
  output logic o_devsel_n,
  output logic o_devsel_oe_n,
  output logic o_trdy_n,
  output logic o_trdy_oe_n,
  output logic o_stop_n,
  output logic o_stop_oe_n,
  output logic [31:0] o_ad,
  output logic o_ad_oe_n,
  // Positive decode window
  input wire logic [31:0] i_win_base,
  input wire logic [31:0] i_win_limit,
  // Read buffer used by target reads
  input wire logic [1:0] i_rd_sel,
  // Master command check
  input wire logic [3:0] i_mst_cmd,
  input wire logic i_mst_type0,
  output logic o_mst_cmd_ok,
  // Buffer ports towards the forwarding logic
  input wire logic [`NUM_BUFS-1:0] i_fill_valid,
  input wire logic [`NUM_BUFS*`ENT_W-1:0] i_fill_data,
  output logic [`NUM_BUFS-1:0] o_fill_ready,
  output logic [`NUM_BUFS-1:0] o_drain_valid,
  output logic [`NUM_BUFS*`ENT_W-1:0] o_drain_data,
  input wire logic [`NUM_BUFS-1:0] i_drain_ready
);

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  function automatic logic is_write(input logic [3:0] cmd);
    return cmd == 4'h3 || cmd == 4'h7 || cmd == 4'hB || cmd == 4'hF;
  endfunction

  // Whether the block may claim a command as target on this bus.
  function automatic logic tgt_claim(input logic [3:0] cmd, input logic [1:0] lo,
                                     input logic idsel, input logic hit);
    case (pci_bridge_pkg::bus_cmd_t'(cmd))
      pci_bridge_pkg::CMD_IO_RD, pci_bridge_pkg::CMD_IO_WR,
      pci_bridge_pkg::CMD_MEM_RD, pci_bridge_pkg::CMD_MEM_WR,
      pci_bridge_pkg::CMD_MEM_RD_MULT, pci_bridge_pkg::CMD_DUAL_ADDR,
      pci_bridge_pkg::CMD_MEM_RD_LINE, pci_bridge_pkg::CMD_MEM_WR_INV: begin
        return hit;
      end
      pci_bridge_pkg::CMD_CFG_RD: begin
        return IS_PRIMARY && idsel && lo == `CFG_TYPE0;
      end
      pci_bridge_pkg::CMD_CFG_WR: begin
        return IS_PRIMARY ? (idsel && lo == `CFG_TYPE0) : (lo == `CFG_TYPE1);
      end
      default: begin
        return 1'b0;
      end
    endcase
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int PW = 39;
  logic [PW-1:0] pin_meta_q;
  logic [PW-1:0] pin_q;
  logic frame_s;
  logic irdy_s;
  logic idsel_s;
  logic [3:0] cbe_s;
  logic [31:0] ad_s;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_meta_q <= {2'h3, 37'h0};
      pin_q <= {2'h3, 37'h0};
    end else begin
      pin_meta_q <= {i_frame_n, i_irdy_n, i_idsel, i_primary_cmd_byte_enable_n, i_ad};
      pin_q <= pin_meta_q;
    end
  end

  assign frame_s = !pin_q[38];
  assign irdy_s = !pin_q[37];
  assign idsel_s = pin_q[36];
  assign cbe_s = pin_q[35:32];
  assign ad_s = pin_q[31:0];

  // ------------------------------------------------------------
  // Buffers
  // ------------------------------------------------------------
  localparam int OWN_WR = IS_PRIMARY ? `WR_DOWN_IDX : `WR_UP_IDX;
  pci_bridge_pkg::tgt_state_t state_q;
  logic [3:0] cmd_q;
  logic [31:0] addr_q;
  logic tgt_push;
  logic [`ENT_W-1:0] tgt_entry;
  logic tgt_pop;
  logic [`NUM_BUFS-1:0] fill_v;
  logic [`NUM_BUFS-1:0] drain_r;
  logic [2:0] rd_idx;
  logic own_ready;
  logic rd_valid;
  logic [`ENT_W-1:0] rd_entry;

  assign rd_idx = 3'(`RD_BASE_IDX) + {1'b0, i_rd_sel};
  assign own_ready = o_fill_ready[OWN_WR];
  assign rd_valid = o_drain_valid[rd_idx];
  assign rd_entry = o_drain_data[rd_idx*`ENT_W +: `ENT_W];

  generate
    for (genvar k = 0; k < `NUM_BUFS; k++) begin : g_buf
      txn_buffer #(.W(`ENT_W), .DEPTH(DEPTH)) u_buf (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_valid(fill_v[k]),
        .i_data(k == OWN_WR ? tgt_entry : i_fill_data[k*`ENT_W +: `ENT_W]),
        .o_ready(o_fill_ready[k]),
        .o_valid(o_drain_valid[k]),
        .o_data(o_drain_data[k*`ENT_W +: `ENT_W]),
        .i_ready(drain_r[k])
      );
      assign fill_v[k] = (k == OWN_WR) ? tgt_push : i_fill_valid[k];
      assign drain_r[k] = (k >= `RD_BASE_IDX && rd_idx == 3'(k) && state_q == pci_bridge_pkg::ST_DATA
                           && !is_write(cmd_q)) ? tgt_pop : i_drain_ready[k];
    end
  endgenerate

  // ------------------------------------------------------------
  // Target sequencer
  // ------------------------------------------------------------
  logic hit;
  logic xfer;
  logic phase_done;
  logic last_phase;
  logic misalign;
  logic at_boundary;
  logic [7:0] beats_q;

  assign hit = ad_s >= i_win_base && ad_s <= i_win_limit;
  assign xfer = irdy_s && !o_trdy_n;
  assign phase_done = irdy_s && (!o_trdy_n || !o_stop_n);
  assign last_phase = (!frame_s && xfer) || (irdy_s && !o_stop_n);
  assign misalign = addr_q[1:0] != `LINEAR_ORDER;
  assign at_boundary = beats_q + 8'h01 >= 8'(BURST_WORDS);
  assign tgt_push = (state_q == pci_bridge_pkg::ST_DEC2 && is_write(cmd_q)) ||
                    (state_q == pci_bridge_pkg::ST_DATA && is_write(cmd_q) && xfer);
  assign tgt_entry = (state_q == pci_bridge_pkg::ST_DEC2) ?
                     {1'b1, cmd_q, 4'h0, addr_q} : {1'b0, cmd_q, ~cbe_s, ad_s};
  assign tgt_pop = xfer;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= pci_bridge_pkg::ST_IDLE;
      cmd_q <= 4'h0;
      addr_q <= `AD_RST;
    end else begin
      case (state_q)
        pci_bridge_pkg::ST_IDLE: begin
          if (frame_s && tgt_claim(cbe_s, ad_s[1:0], idsel_s, hit)) begin
            state_q <= pci_bridge_pkg::ST_DEC1;
            cmd_q <= cbe_s;
            addr_q <= ad_s;
          end
        end
        pci_bridge_pkg::ST_DEC1: begin
          state_q <= pci_bridge_pkg::ST_DEC2;
        end
        pci_bridge_pkg::ST_DEC2: begin
          state_q <= pci_bridge_pkg::ST_DATA;
        end
        pci_bridge_pkg::ST_DATA: begin
          if (phase_done && last_phase) begin
            state_q <= pci_bridge_pkg::ST_TURN;
          end
        end
        pci_bridge_pkg::ST_TURN: begin
          state_q <= pci_bridge_pkg::ST_WAIT;
        end
        default: begin
          if (!frame_s) begin
            state_q <= pci_bridge_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Counts data transfers of the current burst.
  always_ff @(posedge i_mclk) begin
    if (i_rst || state_q != pci_bridge_pkg::ST_DATA) begin
      beats_q <= 8'h00;
    end else if (xfer) begin
      beats_q <= beats_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Target pin drivers
  // ------------------------------------------------------------
  logic drive;
  logic can_move;

  assign drive = state_q == pci_bridge_pkg::ST_DATA;
  assign can_move = is_write(cmd_q) ? own_ready : rd_valid;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_devsel_n <= `PIN_IDLE;
      o_devsel_oe_n <= `PIN_IDLE;
      o_trdy_oe_n <= `PIN_IDLE;
      o_stop_oe_n <= `PIN_IDLE;
    end else begin
      o_devsel_n <= !(state_q == pci_bridge_pkg::ST_DEC2 ||
                      (state_q == pci_bridge_pkg::ST_DATA && !(phase_done && last_phase)));
      o_devsel_oe_n <= !(state_q == pci_bridge_pkg::ST_DEC2 || drive);
      o_trdy_oe_n <= !(state_q == pci_bridge_pkg::ST_DEC2 || drive);
      o_stop_oe_n <= !(state_q == pci_bridge_pkg::ST_DEC2 || drive);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_trdy_n <= `PIN_IDLE;
      o_stop_n <= `PIN_IDLE;
    end else if (state_q != pci_bridge_pkg::ST_DATA || (phase_done && last_phase)) begin
      o_trdy_n <= `PIN_IDLE;
      o_stop_n <= `PIN_IDLE;
    end else begin
      o_trdy_n <= !(can_move && o_stop_n) || (xfer && (misalign || at_boundary));
      if (xfer && (misalign || at_boundary)) begin
        o_stop_n <= 1'b0;
      end
    end
  end

  // Read data goes out, one edge late, for the whole data state of a read, whether target ready is asserted or not.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ad <= `AD_RST;
      o_ad_oe_n <= `PIN_IDLE;
    end else begin
      o_ad <= rd_entry[`ENT_DATA_MSB:0];
      o_ad_oe_n <= !(state_q == pci_bridge_pkg::ST_DATA && !is_write(cmd_q));
    end
  end

  // ------------------------------------------------------------
  // Master command check
  // ------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_mst_cmd_ok <= 1'b0;
    end else begin
      case (pci_bridge_pkg::bus_cmd_t'(i_mst_cmd))
        pci_bridge_pkg::CMD_INT_ACK, pci_bridge_pkg::CMD_RSV4, pci_bridge_pkg::CMD_RSV5,
        pci_bridge_pkg::CMD_RSV8, pci_bridge_pkg::CMD_RSV9: begin
          o_mst_cmd_ok <= 1'b0;
        end
        pci_bridge_pkg::CMD_CFG_RD: begin
          o_mst_cmd_ok <= !IS_PRIMARY;
        end
        pci_bridge_pkg::CMD_CFG_WR: begin
          o_mst_cmd_ok <= !(IS_PRIMARY && i_mst_type0);
        end
        default: begin
          o_mst_cmd_ok <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  medium_devsel_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == pci_bridge_pkg::ST_DEC1 |-> o_devsel_n ##1 o_devsel_n ##1 !o_devsel_n)
    else $error("device select not on second edge after decode");

  no_reserved_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    state_q == pci_bridge_pkg::ST_DEC1 |->
    !(cmd_q inside {4'h4, 4'h5, 4'h8, 4'h9}))
    else $error("reserved command claimed");

  no_intack_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == pci_bridge_pkg::ST_DEC1 |-> cmd_q != 4'h0) and
    (i_mst_cmd == 4'h0 |=> !o_mst_cmd_ok))
    else $error("interrupt acknowledge handled");

  no_special_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == pci_bridge_pkg::ST_DEC1 |-> cmd_q != 4'h1) and
    (i_mst_cmd == 4'h1 |=> o_mst_cmd_ok))
    else $error("special cycle handling wrong");

  type0_block_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!IS_PRIMARY && state_q == pci_bridge_pkg::ST_DEC1 && cmd_q[3:1] == 3'h5)
    |-> addr_q[1:0] == `CFG_TYPE1)
    else $error("type 0 configuration claimed on secondary");

  misalign_stop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == pci_bridge_pkg::ST_DATA && xfer && misalign && !last_phase)
    |=> !o_stop_n && o_trdy_n)
    else $error("misaligned burst not disconnected");

  trdy_claimed_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !o_trdy_n |-> !o_devsel_n && !o_devsel_oe_n)
    else $error("target ready without device select");

  last_phase_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == pci_bridge_pkg::ST_DATA && phase_done && last_phase)
    |=> state_q == pci_bridge_pkg::ST_TURN && o_devsel_n ##1 o_devsel_oe_n)
    else $error("last data phase not ended");

  write_push_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == pci_bridge_pkg::ST_DATA && is_write(cmd_q) && xfer) |-> tgt_push && own_ready)
    else $error("write data taken without buffer room");

endmodule

// *** pci_init_model.sv ***
`timescale 1ns/1ps

module pci_init_model (
  // Clock and target answers
  input wire logic i_mclk,
  input wire logic i_devsel_n,
  input wire logic i_trdy_n,
  input wire logic i_stop_n,
  input wire logic [31:0] i_ad,
  // Initiator drives
  output logic o_frame_n,
  output logic o_irdy_n,
  output logic o_idsel,
  output logic [31:0] o_ad,
  output logic o_ad_oe_n,
  output logic [3:0] o_cbe_n
);
  initial begin
    o_frame_n = 1'b1;
    o_irdy_n = 1'b1;
    o_idsel = 1'b0;
    o_ad = 32'h0000_0000;
    o_ad_oe_n = 1'b1;
    o_cbe_n = 4'hF;
  end

  // ---------------------------------------------------------------
  // One transaction
  // ---------------------------------------------------------------
  // The target sees the pins two edges late, so each data phase is one
  // initiator-ready pulse whose outcome is read three edges after it.
  // A target that stays silent for more than ten edges is treated as a master abort.
  task automatic run(input logic [3:0] cmd, input logic [31:0] addr, input logic sel,
      input int beats, input logic [31:0] wdat, output int lat, output int moved,
      output logic [31:0] rdat);
    logic wr;
    logic done;
    int k;
    int s;
    wr = cmd[0];
    lat = 0;
    moved = 0;
    done = 1'b0;
    rdat = 32'h0000_0000;
    s = 1;
    @(posedge i_mclk);
    o_frame_n <= 1'b0;
    o_ad <= addr;
    o_ad_oe_n <= 1'b0;
    o_cbe_n <= cmd;
    o_idsel <= sel;
    for (k = 1; k < 80 && !done; k++) begin
      @(posedge i_mclk);
      if (lat == 0 && !i_devsel_n) lat = k;
      if (k == s + 3) begin
        if (!i_trdy_n) begin
          moved++;
          rdat = i_ad;
        end
        done = moved == beats || !i_stop_n || (lat == 0 && k > 10);
        s = k;
      end
      if (k == s && !done) begin
        o_idsel <= 1'b0;
        o_cbe_n <= 4'h0;
        o_irdy_n <= 1'b0;
        o_frame_n <= (moved == beats - 1);
        o_ad <= wr ? wdat + 32'(moved) : ~addr;
        o_ad_oe_n <= ~wr;
      end else if (k == s + 1) begin
        o_irdy_n <= 1'b1;
      end
    end
    o_frame_n <= 1'b1;
    o_ad_oe_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask
endmodule

// *** pci_bridge_command_decode_tb_top.sv ***
`timescale 1ns/1ps
`include "pci_bridge_params.svh"

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h %h", $time, (a), (b)); end end

module pci_bridge_command_decode_tb_top;
  localparam int BW = 4;
  localparam int LAT = 4 + `DEVSEL_EDGES;
  localparam logic [31:0] WBASE = 32'h1000_0000;
  localparam logic [31:0] WLIM = 32'h1000_FFFF;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic frame_n, irdy_n, idsel, ini_ad_oe_n;
  logic [31:0] ini_ad, dut_ad;
  logic [3:0] cbe_n, i_mst_cmd;
  logic devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n, dut_ad_oe_n;
  logic [1:0] i_rd_sel;
  logic i_mst_type0, o_mst_cmd_ok;
  logic [`NUM_BUFS-1:0] i_fill_valid, o_fill_ready, o_drain_valid, i_drain_ready;
  logic [`NUM_BUFS*`ENT_W-1:0] i_fill_data, o_drain_data;
  wire logic devsel_w = devsel_oe_n ? 1'b1 : devsel_n;
  wire logic trdy_w = trdy_oe_n ? 1'b1 : trdy_n;
  wire logic stop_w = stop_oe_n ? 1'b1 : stop_n;
  wire logic [31:0] ad_w = !dut_ad_oe_n ? dut_ad : (ini_ad_oe_n ? ~ini_ad : ini_ad);
  int n_errors = 0;
  int compares = 0;
  logic [`ENT_W-1:0] got[$];

  always #2 i_mclk = ~i_mclk;

  pci_bridge_command_decode #(.IS_PRIMARY(1'b1), .BURST_WORDS(BW)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_frame_n(frame_n), .i_irdy_n(irdy_n),
    .i_idsel(idsel), .i_ad(ad_w), .i_primary_cmd_byte_enable_n(cbe_n),
    .o_devsel_n(devsel_n), .o_devsel_oe_n(devsel_oe_n), .o_trdy_n(trdy_n),
    .o_trdy_oe_n(trdy_oe_n), .o_stop_n(stop_n), .o_stop_oe_n(stop_oe_n), .o_ad(dut_ad),
    .o_ad_oe_n(dut_ad_oe_n), .i_win_base(WBASE), .i_win_limit(WLIM), .i_rd_sel(i_rd_sel),
    .i_mst_cmd(i_mst_cmd), .i_mst_type0(i_mst_type0), .o_mst_cmd_ok(o_mst_cmd_ok),
    .i_fill_valid(i_fill_valid), .i_fill_data(i_fill_data), .o_fill_ready(o_fill_ready),
    .o_drain_valid(o_drain_valid), .o_drain_data(o_drain_data),
    .i_drain_ready(i_drain_ready));

  pci_init_model ini (
    .i_mclk(i_mclk), .i_devsel_n(devsel_w), .i_trdy_n(trdy_w), .i_stop_n(stop_w),
    .i_ad(ad_w), .o_frame_n(frame_n), .o_irdy_n(irdy_n), .o_idsel(idsel), .o_ad(ini_ad),
    .o_ad_oe_n(ini_ad_oe_n), .o_cbe_n(cbe_n));

  // Read buffers are left to the target; only the write buffers drain outside.
  always @(posedge i_mclk) begin
    i_drain_ready <= {4'h0, 2'($urandom)};
    if (!i_rst && o_drain_valid[`WR_DOWN_IDX] && i_drain_ready[`WR_DOWN_IDX]) begin
      got.push_back(o_drain_data[`ENT_W-1:0]);
    end
  end

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic logic claim_exp(logic [3:0] c, logic sel, logic [31:0] a);
    case (c)
      4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF: return a >= WBASE && a <= WLIM;
      4'hA, 4'hB: return sel && a[1:0] == `CFG_TYPE0;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic mst_exp(logic [3:0] c, logic t0);
    return !(c inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA}) && !(c == 4'hB && t0);
  endfunction

  task automatic fill(input int idx, input logic [`ENT_W-1:0] w);
    int k;
    @(posedge i_mclk);
    i_fill_valid[idx] <= 1'b1;
    i_fill_data[idx*`ENT_W +: `ENT_W] <= w;
    for (k = 0; k < 50; k++) begin
      @(posedge i_mclk);
      if (o_fill_ready[idx] === 1'b1) break;
    end
    i_fill_valid[idx] <= 1'b0;
  endtask

  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic sel,
      input int beats, input int expm);
    int lat, mv, i;
    logic [31:0] rd, wd;
    logic [`ENT_W-1:0] w;
    logic cl, dc;
    logic [1:0] rs;
    wd = $urandom;
    w = {1'b0, c, 4'hF, 32'($urandom)};
    rs = 2'($urandom);
    cl = claim_exp(c, sel, a);
    dc = cl && c != 4'hD;
    got.delete();
    i_rd_sel <= rs;
    if (dc && !c[0]) fill(`RD_BASE_IDX + rs, w);
    ini.run(c, a, sel, beats, wd, lat, mv, rd);
    repeat (12) @(posedge i_mclk);
    `CHK(lat, cl ? LAT : 0)
    if (dc) `CHK(mv, expm)
    if (dc && !c[0]) `CHK(rd, w[31:0])
    if (dc && c[0]) begin
      `CHK(got.size(), mv + 1)
      `CHK({got[0][40:36], got[0][31:0]}, {1'b1, c, a})
      for (i = 1; i < got.size(); i++) `CHK({got[i][40], got[i][35:0]}, {5'h0F, wd + i - 1})
    end
    if (!cl) `CHK(got.size(), 0)
  endtask

  task automatic complete_run();
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #(20000 * 4);
    n_errors++;
    complete_run();
  end

  initial begin
    logic [31:0] a;
    i_rd_sel = 2'h0;
    i_mst_cmd = 4'h0;
    i_mst_type0 = 1'b0;
    i_fill_valid = '0;
    i_fill_data = '0;
    void'($urandom(32'h5987C26E));
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK({devsel_n, devsel_oe_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n, dut_ad_oe_n}, 7'h7F)
    `CHK({o_mst_cmd_ok, o_drain_valid, o_fill_ready, dut_ad}, {1'b0, 6'h00, 6'h3F, 32'h0})
    for (int c = 0; c < 16; c++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge i_mclk);
        i_mst_cmd <= 4'(c);
        i_mst_type0 <= 1'(t);
        @(posedge i_mclk);
        #1;
        `CHK(o_mst_cmd_ok, mst_exp(4'(c), 1'(t)))
      end
    end
    @(posedge i_mclk);
    for (int c = 0; c < 16; c++) begin
      a = WBASE + ($urandom % 32'h4000) * 4;
      if (c != 13) xfer(4'(c), a, 1'b0, 1, 1);
    end
    xfer(4'hB, a, 1'b1, 1, 1);
    xfer(4'hB, a | 32'h1, 1'b1, 1, 1);
    xfer(4'h7, WLIM & 32'hFFFF_FFFC, 1'b0, 1, 1);
    xfer(4'h7, WBASE - 32'h4, 1'b0, 1, 1);
    xfer(4'h7, a | 32'h2, 1'b0, 3, 1);
    xfer(4'hF, a, 1'b0, BW + 2, BW);
    xfer(4'hD, a, 1'b0, 1, 1);
    complete_run();
  end
endmodule
